//--- cm_consts.svh
`ifndef CM_CONSTS_SVH
`define CM_CONSTS_SVH

// Transfers per I/Q pair and bits per transfer
`define CM_XF_NIB   4'h8
`define CM_XF_BYTE  4'h4
`define CM_XF_WORD  4'h2
`define CM_BITS_NIB  5'h04
`define CM_BITS_BYTE 5'h08
`define CM_BITS_WORD 5'h10

// sqrt(2)/2 in Q15
`define CM_R_Q15     17'sh05a82
`define CM_R_SHIFT   15

// Register byte offsets
`define CM_REG_CTRL   6'h00
`define CM_REG_MODES  6'h04
`define CM_REG_TUNE   6'h08
`define CM_REG_DATA   6'h0c
`define CM_REG_STATUS 6'h10
`define CM_REG_RATE   6'h14

// Control and mode register fields
`define CM_CTRL_WIDTH  1:0
`define CM_CTRL_HB1EN  2
`define CM_CTRL_HB2EN  3
`define CM_CTRL_HB3EN  4
`define CM_CTRL_PREMOD 5
`define CM_CTRL_SHIFT  8:6
`define CM_CTRL_UPD    9
`define CM_CTRL_HB1MD  11:10
`define CM_MODES_HB2   5:0
`define CM_MODES_HB3   13:8

// Reset values
`define CM_CTRL_RST  32'h0000_0002
`define CM_RATE_RST  32'h0000_0000

`endif

//--- cm_dac_path.sv
// Summary of operation
// - Coarse shift applied at interpolated output rate
// - Shifts are complex carrier multiplies only
// - Half-rate shift alternates sign on both channels
// - Quarter-rate shift rotates I,Q,-I,-Q sequence
// - Three-quarter shift rotates I,-Q,-I,Q sequence
// - Eighth-rate shift uses r=sqrt(2)/2 blends
// - Only half-rate shift and no shift keep channels uncoupled
// - Source supplies complex data for other shifts
// - Bus width sets transfers per pair; rate limited
// - Complex bandwidth is twice real bandwidth
// - Second stage alone or second+third allowed
// - Each stage doubles rate of previous one
// - Odd first-stage mode should enable premodulation
// - 32-bit tuning word; rate doubles with first stage
// - Tuning word loads on update bit rising edge
// - First stage 2-bit mode, others 6-bit
`timescale 1ns/1ps
`include "cm_consts.svh"
module cm_dac_path
  import cm_pkg::*;
#(
  parameter int DW = 16
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // Sample link
  cm_link_if.dev             link,
  // Converter samples
  output logic signed [DW-1:0] dac_i,
  output logic signed [DW-1:0] dac_q,
  output logic                 dac_valid,
  // Status
  output logic                 underrun,
  output logic [3:0]           interp_factor,
  output logic                 iq_coupled
);

  function automatic logic [3:0] xfer_count(input cm_width_t w);
    unique case (w)
      CM_W_NIB:  return `CM_XF_NIB;
      CM_W_BYTE: return `CM_XF_BYTE;
      default:   return `CM_XF_WORD;
    endcase
  endfunction : xfer_count

  function automatic logic [4:0] xfer_bits(input cm_width_t w);
    unique case (w)
      CM_W_NIB:  return `CM_BITS_NIB;
      CM_W_BYTE: return `CM_BITS_BYTE;
      default:   return `CM_BITS_WORD;
    endcase
  endfunction : xfer_bits

  // Extreme inputs can wrap; headroom is the source's job
  function automatic logic signed [DW-1:0] rmul(input logic signed [DW:0] x);
    logic signed [2*DW+1:0] p;
    p = x * `CM_R_Q15;
    return p[`CM_R_SHIFT +: DW];
  endfunction : rmul

  function automatic logic [2*DW-1:0] mix(input logic signed [DW-1:0] i,
                                          input logic signed [DW-1:0] q,
                                          input cm_shift_t m,
                                          input logic [2:0] ph);
    logic signed [DW-1:0] rp;
    logic signed [DW-1:0] rm;
    logic signed [DW-1:0] oi;
    logic signed [DW-1:0] oq;
    rp = rmul((DW+1)'(i) + (DW+1)'(q));
    rm = rmul((DW+1)'(q) - (DW+1)'(i));
    oi = i;
    oq = q;
    unique case (m)
      CM_SH_HALF: begin
        oi = ph[0] ? -i : i;
        oq = ph[0] ? -q : q;
      end
      CM_SH_QTR: begin
        unique case (ph[1:0])
          2'h0: begin oi = i;  oq = q;  end
          2'h1: begin oi = q;  oq = -i; end
          2'h2: begin oi = -i; oq = -q; end
          default: begin oi = -q; oq = i; end
        endcase
      end
      CM_SH_3QTR: begin
        unique case (ph[1:0])
          2'h0: begin oi = i;  oq = q;  end
          2'h1: begin oi = -q; oq = i;  end
          2'h2: begin oi = -i; oq = -q; end
          default: begin oi = q; oq = -i; end
        endcase
      end
      CM_SH_EIGHTH: begin
        unique case (ph)
          3'h0: begin oi = i;   oq = q;   end
          3'h1: begin oi = rp;  oq = rm;  end
          3'h2: begin oi = q;   oq = -i;  end
          3'h3: begin oi = rm;  oq = -rp; end
          3'h4: begin oi = -i;  oq = -q;  end
          3'h5: begin oi = -rp; oq = -rm; end
          3'h6: begin oi = -q;  oq = i;   end
          default: begin oi = -rm; oq = rp; end
        endcase
      end
      default: begin
        oi = i;
        oq = q;
      end
    endcase
    return {oi, oq};
  endfunction : mix

  logic [2*DW-1:0]      acc_q;
  logic [2*DW-1:0]      acc_d;
  logic [3:0]           cnt_q;
  logic [3:0]           cnt_d;
  logic [2*DW-1:0]      pair_q;
  logic                 pair_v_q;
  logic                 run_q;
  logic [2:0]           rc_q;
  logic [7:0]           tick_q;
  logic [1:0]           nstg;
  logic [3:0]           fac;
  logic                 load;
  logic                 pm_q;
  logic signed [DW-1:0] s_i_q;
  logic signed [DW-1:0] s_q_q;
  logic [31:0]          ftw_act_q;
  logic                 upd_q;
  logic [31:0]          ph_acc_q;
  logic [3:0]           nco_mask;
  logic                 nco_step;
  logic                 csign;
  logic [2*DW-1:0]      coarse;
  logic [2*DW-1:0]      fine;
  logic [4:0]           bits;

  // Link assembly, I then Q, most significant part first
  assign bits       = xfer_bits(link.width);
  assign link.ready = !pair_v_q;
  assign cnt_d      = link.first ? 4'h1 : cnt_q + 4'h1;

  always_comb begin
    acc_d = (acc_q << bits) | (2*DW)'(link.data & 16'((17'h1 << bits) - 17'h1));
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_q    <= '0;
      cnt_q    <= '0;
      pair_q   <= '0;
      pair_v_q <= 1'b0;
    end else begin
      if (link.valid && !pair_v_q) begin
        acc_q <= acc_d;
        if (cnt_d == xfer_count(link.width)) begin
          pair_q   <= acc_d;
          pair_v_q <= 1'b1;
          cnt_q    <= '0;
        end else begin
          cnt_q <= cnt_d;
        end
      end else if (load) begin
        pair_v_q <= 1'b0;
      end
    end
  end

  // Stage count sets the interpolation factor
  assign nstg          = 2'(link.hb1_en) + 2'(link.hb2_en) + 2'(link.hb3_en);
  assign fac           = 4'h1 << nstg;
  assign interp_factor = fac;
  assign load          = (4'(rc_q) == fac - 4'h1);
  assign iq_coupled    = (link.shift != CM_SH_HALF) && (link.shift != CM_SH_NONE);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rc_q   <= '0;
      tick_q <= '0;
    end else begin
      rc_q   <= load ? 3'h0 : rc_q + 3'h1;
      tick_q <= tick_q + 8'h1;
    end
  end

  // Hold stands in for filtering; a zero pair is sent on underrun
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_i_q    <= '0;
      s_q_q    <= '0;
      pm_q     <= 1'b0;
      run_q    <= 1'b0;
      underrun <= 1'b0;
    end else begin
      underrun <= load && run_q && !pair_v_q;
      if (load) begin
        pm_q <= !pm_q;
        if (pair_v_q) begin
          run_q <= 1'b1;
          // Premodulation: half input rate shift
          s_i_q <= (link.premod && pm_q) ? -pair_q[2*DW-1:DW] : pair_q[2*DW-1:DW];
          s_q_q <= (link.premod && pm_q) ? -pair_q[DW-1:0] : pair_q[DW-1:0];
        end else begin
          s_i_q <= '0;
          s_q_q <= '0;
        end
      end
    end
  end

  // Odd center modes flip sign at that stage's own rate
  always_comb begin
    csign = 1'b0;
    if (link.hb1_en && link.hb1_mode[0]) begin
      csign = csign ^ tick_q[nstg - 2'h1];
    end
    if (link.hb2_en && link.hb2_mode[0]) begin
      csign = csign ^ tick_q[nstg - 2'h1 - 2'(link.hb1_en)];
    end
    if (link.hb3_en && link.hb3_mode[0]) begin
      csign = csign ^ tick_q[2'h0];
    end
  end

  // Tuning word held until update bit rises
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      upd_q     <= 1'b0;
      ftw_act_q <= '0;
    end else begin
      upd_q <= link.ftw_upd;
      if (link.ftw_upd && !upd_q) begin
        ftw_act_q <= link.carrier_tuning_word;
      end
    end
  end

  assign nco_mask = link.hb1_en ? (fac >> 1) - 4'h1 : fac - 4'h1;
  assign nco_step = (tick_q[3:0] & nco_mask) == 4'h0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ph_acc_q <= '0;
    end else if (nco_step) begin
      ph_acc_q <= ph_acc_q + ftw_act_q;
    end
  end

  // Coarse mix after the stages at output rate, then quadrant-only fine rotation
  assign coarse = mix(s_i_q, s_q_q, link.shift, tick_q[2:0]);
  assign fine   = mix(coarse[2*DW-1:DW], coarse[DW-1:0], CM_SH_QTR,
                      {1'b0, ph_acc_q[31:30]});

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dac_i     <= '0;
      dac_q     <= '0;
      dac_valid <= 1'b0;
    end else begin
      dac_valid <= run_q;
      dac_i     <= csign ? -fine[2*DW-1:DW] : fine[2*DW-1:DW];
      dac_q     <= csign ? -fine[DW-1:0] : fine[DW-1:0];
    end
  end
endmodule : cm_dac_path

//--- cm_fifo.sv
`timescale 1ns/1ps
module cm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  logic             full;
  logic             empty;

  // Extra pointer bit tells full from empty
  assign empty     = (wp_q == rp_q);
  assign full      = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp_q[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (in_valid && !full) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (in_valid && !full) begin
        wp_q <= wp_q + 1'b1;
      end
      if (out_ready && !empty) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule : cm_fifo

//--- cm_link_assertions.sv
`timescale 1ns/1ps
`include "cm_consts.svh"
module cm_link_assertions
  import cm_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Link
  input wire logic [15:0] data,
  input wire logic        valid,
  input wire logic        ready,
  input wire logic        first,
  input wire cm_width_t   width
);
  logic       take;
  logic       last;
  logic [3:0] n_d;
  logic [3:0] n_q;
  logic [3:0] xf_q;

  assign take = valid && ready;
  assign n_d  = (width == CM_W_NIB) ? `CM_XF_NIB : (width == CM_W_BYTE) ? `CM_XF_BYTE : `CM_XF_WORD;
  assign last = take && !first && (xf_q == n_q - 4'h1);

  // Width latched per pair, so a later width change cannot upset the count
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      xf_q <= 4'h0;
      n_q  <= `CM_XF_WORD;
    end else if (take) begin
      xf_q <= first ? 4'h1 : xf_q + 4'h1;
      n_q  <= first ? n_d : n_q;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_stall_valid;
    valid && !ready |=> valid;
  endproperty
  a_stall_valid: assert property (p_stall_valid) else $error("valid dropped");
  property p_stall_data;
    valid && !ready |=> $stable(data) && $stable(first);
  endproperty
  a_stall_data: assert property (p_stall_data) else $error("data moved in stall");
  property p_back_to_back;
    take && !last |=> valid && !first;
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("pair broken");
  property p_ready_drop;
    last |=> !ready;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready held");
  property p_pair_len;
    take && !first |-> xf_q != 4'h0 && xf_q < n_q;
  endproperty
  a_pair_len: assert property (p_pair_len) else $error("pair too long");
  property p_first_whole;
    take && first |-> xf_q == 4'h0 || xf_q == n_q;
  endproperty
  a_first_whole: assert property (p_first_whole) else $error("pair cut short");
  property p_ready_return;
    $fell(ready) |-> ##[1:9] ready;
  endproperty
  a_ready_return: assert property (p_ready_return) else $error("no slot");
  property p_word_pair;
    (width == CM_W_WORD) && take && first |=> take ##1 !ready;
  endproperty
  a_word_pair: assert property (p_word_pair) else $error("word pair");
endmodule : cm_link_assertions

//--- cm_link_if.sv
`timescale 1ns/1ps
interface cm_link_if;
  import cm_pkg::*;
  logic [15:0] data;
  logic        valid;
  logic        ready;
  logic        first;
  cm_width_t   width;
  logic        hb1_en;
  logic        hb2_en;
  logic        hb3_en;
  logic [1:0]  hb1_mode;
  logic [5:0]  hb2_mode;
  logic [5:0]  hb3_mode;
  logic        premod;
  cm_shift_t   shift;
  logic [31:0] carrier_tuning_word;
  logic        ftw_upd;

  modport dev (input data, valid, first, width, hb1_en, hb2_en, hb3_en,
               hb1_mode, hb2_mode, hb3_mode, premod, shift, carrier_tuning_word, ftw_upd,
               output ready);
  modport src (output data, valid, first, width, hb1_en, hb2_en, hb3_en,
               hb1_mode, hb2_mode, hb3_mode, premod, shift, carrier_tuning_word, ftw_upd,
               input ready);
endinterface : cm_link_if

//--- cm_pkg.sv
package cm_pkg;

  typedef enum logic [1:0] {CM_W_NIB, CM_W_BYTE, CM_W_WORD} cm_width_t;
  typedef enum logic [2:0] {CM_SH_NONE, CM_SH_HALF, CM_SH_QTR, CM_SH_3QTR,
                            CM_SH_EIGHTH} cm_shift_t;
  typedef enum logic {CM_ST_IDLE, CM_ST_SEND} cm_ser_t;

  // Max data rate (0.25 MSPS units) and real bandwidth (0.5 MHz units)
  function automatic logic [31:0] cm_limits(input cm_width_t w,
                                            input logic [2:0] stg);
    logic [15:0] fmax;
    logic [15:0] bw;
    fmax = 16'h0267;
    bw   = 16'h0000;
    unique case (stg)
      3'b000: bw = 16'h0096;
      3'b001: bw = 16'h0078;
      3'b010: bw = 16'h004b;
      3'b011: bw = 16'h0078;
      3'b110: bw = 16'h004b;
      3'b111: bw = 16'h0078;
      default: bw = 16'h0000;
    endcase
    if (w == CM_W_BYTE) begin
      fmax = (stg == 3'b111) ? 16'h0267 : 16'h04ce;
      bw   = (stg == 3'b111) ? bw : {bw[14:0], 1'b0};
    end else if (w == CM_W_WORD) begin
      unique case (stg)
        3'b000: begin fmax = 16'h099c; bw = 16'h0258; end
        3'b001: begin fmax = 16'h07d0; bw = 16'h0190; end
        3'b010: begin fmax = 16'h099c; bw = 16'h012c; end
        3'b011: begin fmax = 16'h04ce; bw = 16'h00f0; end
        3'b110: begin fmax = 16'h04ce; bw = 16'h0096; end
        3'b111: begin fmax = 16'h0267; bw = 16'h0078; end
        default: begin fmax = 16'h0000; bw = 16'h0000; end
      endcase
    end
    return {fmax, bw};
  endfunction : cm_limits

endpackage : cm_pkg

//--- cm_src.sv
`timescale 1ns/1ps
`include "cm_consts.svh"
module cm_src
  import cm_pkg::*;
#(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Sample link
  cm_link_if.src           link
);

  function automatic logic [31:0] lanes(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : lanes

  logic [31:0] ctrl_q;
  logic [31:0] modes_q;
  logic [31:0] ftw_q;
  logic [31:0] rate_q;
  logic        req;
  logic        is_data;
  logic        ack_d;
  logic        f_in_ready;
  logic [31:0] f_out;
  logic        f_out_valid;
  logic        f_out_ready;
  logic [31:0] lim;
  logic [2:0]  stg;
  logic        cfg_bad;
  logic        rate_bad;
  logic [31:0] status;
  cm_ser_t     st_q;
  logic [31:0] sh_q;
  logic [3:0]  left_q;
  logic        first_q;

  // Data writes wait for room, so software is stalled on a full FIFO
  // Writes land at the edge the master samples ack; room cannot vanish meanwhile
  assign req     = wb_cyc_i && wb_stb_i;
  assign is_data = wb_we_i && (wb_adr_i == `CM_REG_DATA);
  assign ack_d   = req && !wb_ack_o && !(is_data && !f_in_ready);

  assign stg      = {ctrl_q[`CM_CTRL_HB3EN], ctrl_q[`CM_CTRL_HB2EN],
                     ctrl_q[`CM_CTRL_HB1EN]};
  assign lim      = cm_limits(cm_width_t'(ctrl_q[`CM_CTRL_WIDTH]), stg);
  assign cfg_bad  = (lim[15:0] == 16'h0000);
  assign rate_bad = (rate_q[15:0] > lim[31:16]);
  assign status   = {lim[14:0], 1'b0,
                     10'h000,
                     ctrl_q[`CM_CTRL_HB1MD] != 2'h0 && ctrl_q[`CM_CTRL_HB1MD] != 2'h2
                       && !ctrl_q[`CM_CTRL_PREMOD],
                     link.shift != CM_SH_HALF && link.shift != CM_SH_NONE,
                     rate_bad, cfg_bad, !f_in_ready, !f_out_valid};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= ack_d;
      if (ack_d && !wb_we_i) begin
        unique case (wb_adr_i)
          `CM_REG_CTRL:   wb_dat_o <= ctrl_q;
          `CM_REG_MODES:  wb_dat_o <= modes_q;
          `CM_REG_TUNE:   wb_dat_o <= ftw_q;
          `CM_REG_STATUS: wb_dat_o <= status;
          `CM_REG_RATE:   wb_dat_o <= rate_q;
          default:        wb_dat_o <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q  <= `CM_CTRL_RST;
      modes_q <= '0;
      ftw_q   <= '0;
      rate_q  <= `CM_RATE_RST;
    end else if (wb_ack_o && req && wb_we_i) begin
      unique case (wb_adr_i)
        `CM_REG_CTRL:  ctrl_q  <= lanes(ctrl_q, wb_dat_i, wb_sel_i);
        `CM_REG_MODES: modes_q <= lanes(modes_q, wb_dat_i, wb_sel_i);
        `CM_REG_TUNE:  ftw_q   <= lanes(ftw_q, wb_dat_i, wb_sel_i);
        `CM_REG_RATE:  rate_q  <= lanes(rate_q, wb_dat_i, wb_sel_i);
        default:       ;
      endcase
    end
  end

  cm_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_data   (wb_dat_i),
    .in_valid  (wb_ack_o && req && is_data),
    .in_ready  (f_in_ready),
    .out_data  (f_out),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready)
  );

  // Serialiser: I then Q, most significant part first
  assign f_out_ready = (st_q == CM_ST_IDLE);
  assign link.valid  = (st_q == CM_ST_SEND);
  assign link.first  = first_q;
  always_comb begin
    unique case (link.width)
      CM_W_NIB:  link.data = {12'h000, sh_q[31:28]};
      CM_W_BYTE: link.data = {8'h00, sh_q[31:24]};
      default:   link.data = sh_q[31:16];
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q    <= CM_ST_IDLE;
      sh_q    <= '0;
      left_q  <= '0;
      first_q <= 1'b0;
    end else begin
      unique case (st_q)
        CM_ST_IDLE: begin
          if (f_out_valid) begin
            st_q    <= CM_ST_SEND;
            sh_q    <= f_out;
            first_q <= 1'b1;
            unique case (link.width)
              CM_W_NIB:  left_q <= `CM_XF_NIB;
              CM_W_BYTE: left_q <= `CM_XF_BYTE;
              default:   left_q <= `CM_XF_WORD;
            endcase
          end
        end
        CM_ST_SEND: begin
          if (link.ready) begin
            first_q <= 1'b0;
            left_q  <= left_q - 4'h1;
            unique case (link.width)
              CM_W_NIB:  sh_q <= sh_q << `CM_BITS_NIB;
              CM_W_BYTE: sh_q <= sh_q << `CM_BITS_BYTE;
              default:   sh_q <= sh_q << `CM_BITS_WORD;
            endcase
            if (left_q == 4'h1) begin
              st_q <= CM_ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Configuration straight from registers
  assign link.width    = cm_width_t'(ctrl_q[`CM_CTRL_WIDTH]);
  assign link.hb1_en   = ctrl_q[`CM_CTRL_HB1EN];
  assign link.hb2_en   = ctrl_q[`CM_CTRL_HB2EN];
  assign link.hb3_en   = ctrl_q[`CM_CTRL_HB3EN];
  assign link.hb1_mode = ctrl_q[`CM_CTRL_HB1MD];
  assign link.hb2_mode = modes_q[`CM_MODES_HB2];
  assign link.hb3_mode = modes_q[`CM_MODES_HB3];
  assign link.premod   = ctrl_q[`CM_CTRL_PREMOD];
  assign link.shift    = cm_shift_t'(ctrl_q[`CM_CTRL_SHIFT]);
  assign link.carrier_tuning_word      = ftw_q;
  assign link.ftw_upd  = ctrl_q[`CM_CTRL_UPD];
endmodule : cm_src

//--- testbench.sv
`timescale 1ns/1ps
`include "cm_consts.svh"
module testbench;
  import cm_pkg::*;
  localparam logic [11:0] TC [11] = '{12'h006, 12'h006, 12'h000, 12'h01d, 12'h012, 12'h406,
                                      12'h426, 12'h082, 12'h042, 12'h00a, 12'h01a};
  localparam logic [15:0] TR [11] = '{16'h07d0, 16'h07d1, 16'h0268, 16'h0, 16'h0, 16'h0,
                                      16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  localparam logic [31:0] TS [11] = '{32'h0320_0001, 32'h0320_0009, 32'h012c_0009,
    32'h00f0_0001, 32'h0000_0005, 32'h0320_0021, 32'h0320_0001, 32'h04b0_0011,
    32'h04b0_0001, 32'h0258_0001, 32'h012c_0001};
  logic               mclk = 1'b0;
  logic               rst = 1'b1;
  logic               cyc = 1'b0;
  logic               we = 1'b0;
  logic [5:0]         adr = 6'h00;
  logic [3:0]         sel = 4'h0;
  logic [31:0]        wdat = 32'h0;
  logic [31:0]        rdat, r;
  logic               ack, coupled;
  logic               dvalid, urun;
  logic               urun_seen = 1'b0;
  logic [3:0]         factor;
  logic signed [15:0] dac_i, dac_q;
  logic signed [15:0] si [16];
  logic signed [15:0] sq [16];
  int                 mismatches = 0;
  int                 check_count = 0;
  int                 ticks = 0;

  cm_link_if link ();
  cm_src i_cm_src (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .link(link));
  cm_dac_path i_cm_dac_path (.mclk(mclk), .rst(rst), .link(link), .dac_i(dac_i),
    .dac_q(dac_q), .dac_valid(dvalid), .underrun(urun), .interp_factor(factor),
    .iq_coupled(coupled));
  cm_link_assertions i_cm_link_assertions (.mclk(mclk), .rst(rst), .data(link.data),
    .valid(link.valid),
    .ready(link.ready), .first(link.first), .width(link.width));

  always #2.5 mclk = ~mclk;

  always @(posedge mclk) begin
    if (urun === 1'b1) urun_seen <= 1'b1;
  end

  // Whole run needs a few thousand cycles
  always @(posedge mclk) begin
    ticks = ticks + 1;
    if (ticks == 20000) begin
      mismatches = mismatches + 1;
      stop_test();
    end
  end

  task automatic stop_test;
    if (mismatches == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge mclk);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do @(posedge mclk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
  endtask : wb

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(r, e);
  endtask : rd

  // Drain first: leftover pairs would otherwise leak into the next window
  task automatic run(input logic [31:0] ctl, input logic [31:0] p, input int n);
    repeat (80) @(posedge mclk);
    wb(1'b1, `CM_REG_CTRL, ctl, 4'hf);
    repeat (n) wb(1'b1, `CM_REG_DATA, p, 4'hf);
  endtask : run

  task automatic grab;
    for (int n = 0; n < 16; n++) begin
      @(posedge mclk);
      si[n] = dac_i;
      sq[n] = dac_q;
    end
  endtask : grab

  function automatic logic [31:0] mixed(input cm_shift_t m, input int p,
                                        input logic signed [15:0] i, input logic signed [15:0] q);
    case (m)
      CM_SH_HALF:   return p[0] ? {-i, -q} : {i, q};
      CM_SH_QTR:    return p[1] ? (p[0] ? {-q, i} : {-i, -q}) : (p[0] ? {q, -i} : {i, q});
      CM_SH_3QTR:   return p[1] ? (p[0] ? {q, -i} : {-i, -q}) : (p[0] ? {-q, i} : {i, q});
      CM_SH_EIGHTH: return mixed(CM_SH_QTR, p >> 1, p[0] ? 16'sh5a82 : i, p[0] ? 16'sh0 : q);
      default:      return {i, q};
    endcase
  endfunction : mixed

  function automatic logic [31:0] seen(input logic signed [15:0] v);
    seen = 32'h0;
    for (int n = 0; n < 16; n++) if (si[n] === v) seen = 32'h1;
  endfunction : seen

  // Mixing phase is free running, so every start offset is tried
  task automatic mix(input cm_shift_t m, input logic signed [15:0] i, input logic signed [15:0] q);
    logic ok;
    logic hit;
    ok = 1'b0;
    run({23'h0, m, 6'h1e}, {i, q}, 6);
    grab();
    for (int k = 0; k < 8; k++) begin
      hit = 1'b1;
      for (int n = 0; n < 16; n++) if (mixed(m, k + n, i, q) !== {si[n], sq[n]}) hit = 1'b0;
      ok = ok | hit;
    end
    chk({31'h0, ok}, 32'h1);
  endtask : mix

  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd(`CM_REG_CTRL, `CM_CTRL_RST);
    rd(`CM_REG_STATUS, 32'h04b0_0001);
    chk({31'h0, dvalid}, 32'h0);
    wb(1'b1, 6'h18, 32'hffff_ffff, 4'hf);
    rd(6'h18, 32'h0);
    wb(1'b1, `CM_REG_MODES, 32'h0000_2a15, 4'h1);
    rd(`CM_REG_MODES, 32'h0000_0015);
    wb(1'b1, `CM_REG_MODES, 32'h0000_2a15, 4'h2);
    rd(`CM_REG_MODES, 32'h0000_2a15);
    wb(1'b1, `CM_REG_MODES, 32'h0, 4'hf);
    wb(1'b1, `CM_REG_TUNE, 32'h8000_0000, 4'hf);
    rd(`CM_REG_TUNE, 32'h8000_0000);
    for (int e = 0; e < 11; e++) begin
      wb(1'b1, `CM_REG_CTRL, {20'h0, TC[e]}, 4'hf);
      wb(1'b1, `CM_REG_RATE, {16'h0, TR[e]}, 4'hf);
      rd(`CM_REG_STATUS, TS[e]);
      chk({31'h0, coupled}, {31'h0, TS[e][4]});
      if (!TS[e][2]) chk({28'h0, factor}, 32'h1 << $countones(TC[e][4:2]));
    end
    mix(CM_SH_NONE, 16'sh1000, 16'sh0300);
    mix(CM_SH_HALF, 16'sh1000, 16'sh0300);
    mix(CM_SH_QTR, 16'sh1000, 16'sh0300);
    mix(CM_SH_3QTR, 16'sh1000, 16'sh0300);
    mix(CM_SH_EIGHTH, 16'sh4000, 16'sh4000);
    for (int w = 0; w < 3; w++) begin
      run({27'h0, 3'b111, w[1:0]}, 32'h5e3c_a1d7 + w, 1);
      for (int n = 0; n < 64 && {dac_i, dac_q} !== 32'h5e3c_a1d7 + w; n++) @(posedge mclk);
      chk({dac_i, dac_q}, 32'h5e3c_a1d7 + w);
    end
    // Nibble link drains slower than the bus fills
    run(32'h1c, 32'h0123_4567, 16);
    rd(`CM_REG_STATUS, 32'h00f0_0002);
    repeat (300) @(posedge mclk);
    chk({31'h0, dvalid}, 32'h1);
    chk({31'h0, urun_seen}, 32'h1);
    rd(`CM_REG_STATUS, 32'h00f0_0001);
    run(32'h1e, 32'h1000_0300, 6);
    grab();
    chk(seen(16'shf000), 32'h0);
    run(32'h21e, 32'h1000_0300, 6);
    grab();
    chk(seen(16'shf000), 32'h1);
    stop_test();
  end
endmodule : testbench
